// ---- design/auto_mute_pkg.sv ----
// Constants for the auto-mute and emergency ramp register bank.
package auto_mute_pkg;

	// APB geometry
	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;
	localparam int INDEX_W = ADDR_W - 2;

	// Register indexes; byte address is four times the index
	localparam logic [INDEX_W-1:0] IDX_EMERGENCY_RAMP = 10'h04F;
	localparam logic [INDEX_W-1:0] IDX_AUTO_MUTE_CONTROL = 10'h050;
	localparam logic [INDEX_W-1:0] IDX_AUTO_MUTE_DURATION = 10'h051;
	localparam logic [INDEX_W-1:0] IDX_OUTPUT_STAGE_BANDWIDTH = 10'h053;
	localparam logic [INDEX_W-1:0] IDX_MUTE_STATUS = 10'h058;

	// Reset values
	localparam logic [7:0] RST_EMERGENCY_RAMP = 8'h30;
	localparam logic [7:0] RST_AUTO_MUTE_CONTROL = 8'h07;
	localparam logic [7:0] RST_AUTO_MUTE_DURATION = 8'h00;
	localparam logic [7:0] RST_OUTPUT_STAGE_BANDWIDTH = 8'h00;

	// Field positions
	localparam int LEFT_ENABLE_BIT = 0;
	localparam int RIGHT_ENABLE_BIT = 1;
	localparam int GROUP_MUTE_BIT = 2;
	localparam int LEFT_RUN_LSB = 4;
	localparam int RIGHT_RUN_LSB = 0;
	localparam int RUN_CODE_W = 3;
	localparam int BANDWIDTH_LSB = 5;
	localparam int BANDWIDTH_W = 2;
	localparam int EMERGENCY_SPEED_LSB = 6;
	localparam int EMERGENCY_STEP_LSB = 4;
	localparam int STAT_LEFT_MUTED_BIT = 0;
	localparam int STAT_RIGHT_MUTED_BIT = 1;
	localparam int STAT_EMERGENCY_BIT = 2;
	localparam int STAT_LEFT_SILENT_BIT = 3;
	localparam int STAT_RIGHT_SILENT_BIT = 4;

	// Emergency speed codes
	localparam logic [1:0] SPEED_EVERY_1 = 2'h0;
	localparam logic [1:0] SPEED_EVERY_2 = 2'h1;
	localparam logic [1:0] SPEED_EVERY_4 = 2'h2;
	localparam logic [1:0] SPEED_INSTANT = 2'h3;
	localparam logic [1:0] PHASE_MASK_1 = 2'h0;
	localparam logic [1:0] PHASE_MASK_2 = 2'h1;
	localparam logic [1:0] PHASE_MASK_4 = 2'h3;

	// Attenuation in 0.5 dB units; all ones is mute
	localparam logic [7:0] ATTEN_NONE = 8'h00;
	localparam logic [7:0] ATTEN_MUTE = 8'hFF;
	localparam logic [7:0] STEP_4_DB = 8'h08;
	localparam logic [7:0] STEP_2_DB = 8'h04;
	localparam logic [7:0] STEP_1_DB = 8'h02;
	localparam logic [7:0] STEP_HALF_DB = 8'h01;
	localparam logic [7:0] NORMAL_STEP = 8'h01;

	// Timing: sample rate and clock
	localparam int CLOCK_KHZ = 100000;
	localparam int RATE_KHZ = 96;
	localparam int SAMPLE_DIV = CLOCK_KHZ / RATE_KHZ;
	localparam int RUN_W = 19;
	localparam int ZERO_RUN_US [8] = '{11500, 53000, 106500, 266500, 535000, 1065000, 2665000, 5330000};

	// Zero-run length in samples at the reference rate
	function automatic logic [RUN_W-1:0] zero_run_limit(input logic [RUN_CODE_W-1:0] code);
		zero_run_limit = RUN_W'(ZERO_RUN_US[code] * RATE_KHZ / 1000);
	endfunction

	// Emergency step size in attenuation units
	function automatic logic [7:0] emergency_step(input logic [1:0] code);
		case (code)
			2'h0: emergency_step = STEP_4_DB;
			2'h1: emergency_step = STEP_2_DB;
			2'h2: emergency_step = STEP_1_DB;
			default: emergency_step = STEP_HALF_DB;
		endcase
	endfunction

endpackage

// ---- design/auto_mute_ramp.sv ----
// Sample FIFO and the auto-mute / emergency ramp block with its APB registers.
//
// Local design decision: the APB slave port.
`timescale 1ns/1ns

module sample_fifo #(
	parameter int WIDTH = 48,
	parameter int DEPTH = 16
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// Drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0] wr_ptr;
		logic [AW-1:0] rd_ptr;
		logic [AW:0] count;
		logic room;
		logic filled;
	} fifo_state_t;

	fifo_state_t q;
	fifo_state_t next_q;
	logic push;
	logic pop;

	// Flags are registered so in_ready and out_valid come straight from flops
	assign in_ready = q.room;
	assign out_valid = q.filled;
	assign out_data = q.mem[q.rd_ptr];

	// Pointer wrap assumes a power-of-two depth
	always_comb begin
		next_q = q;
		push = in_valid && q.room;
		pop = out_ready && q.filled;
		if (push) begin
			next_q.mem[q.wr_ptr] = in_data;
			next_q.wr_ptr = q.wr_ptr + AW'(1);
		end
		if (pop) begin
			next_q.rd_ptr = q.rd_ptr + AW'(1);
		end
		next_q.count = q.count + (AW + 1)'(push) - (AW + 1)'(pop);
		next_q.room = next_q.count != (AW + 1)'(DEPTH);
		next_q.filled = next_q.count != '0;
	end

	// State register
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			q <= '0;
			q.room <= 1'b1;
		end else begin
			q <= next_q;
		end
	end
endmodule // sample_fifo

module auto_mute_ramp
	import auto_mute_pkg::*;
#(
	parameter int SAMPLE_W = 24,
	parameter int FIFO_DEPTH = 16,
	parameter int SAMPLE_DIVIDER = SAMPLE_DIV,
	parameter int RUN_SHIFT = 0
) (
	// APB slave
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [DATA_W-1:0] pwdata,
	output logic [DATA_W-1:0] prdata,
	output logic pready,
	output logic pslverr,
	// Incoming sample frames
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [SAMPLE_W-1:0] in_left,
	input wire logic [SAMPLE_W-1:0] in_right,
	// Outgoing sample frames, one per sample period while the FIFO holds a frame
	output logic out_valid,
	output logic [SAMPLE_W-1:0] out_left,
	output logic [SAMPLE_W-1:0] out_right,
	output logic [7:0] left_attenuation,
	output logic [7:0] right_attenuation,
	// Fault inputs that force an emergency ramp
	input wire logic clock_fault,
	input wire logic supply_loss,
	// Status and analog control
	output logic left_muted,
	output logic right_muted,
	output logic [BANDWIDTH_W-1:0] loop_bandwidth_select
);
	localparam int DIV_W = $clog2(SAMPLE_DIVIDER + 1);
	localparam int FRAME_W = 2 * SAMPLE_W;

	typedef struct packed {
		logic [7:0] auto_mute_control;
		logic [7:0] auto_mute_duration;
		logic [7:0] output_stage_bandwidth;
		logic [7:0] emergency_ramp_control;
		logic [DATA_W-1:0] rdata;
		logic ready;
		logic slverr;
		logic [DIV_W-1:0] div;
		logic [1:0] phase;
		logic emergency;
		logic [1:0][RUN_W-1:0] run;
		logic [1:0] muted;
		logic [1:0][7:0] atten;
		logic ovalid;
		logic [1:0][SAMPLE_W-1:0] osample;
	} state_t;

	state_t q;
	state_t next_q;

	logic tick;
	logic frame_valid;
	logic [FRAME_W-1:0] frame;
	logic [1:0][SAMPLE_W-1:0] sample;
	logic [1:0][RUN_W-1:0] next_run;
	logic [1:0] qualify;
	logic [1:0] want_mute;
	logic [INDEX_W-1:0] index;
	logic aligned;
	logic [1:0] speed;
	logic [1:0] phase_mask;
	logic [7:0] step;
	logic update_due;
	logic [8:0] sum;

	// Sample-rate enable: one pulse per sample period
	assign tick = q.div == DIV_W'(SAMPLE_DIVIDER - 1);

	// A frame is taken only on the sample tick, so a fast source fills the FIFO and stalls
	sample_fifo #(
		.WIDTH(FRAME_W),
		.DEPTH(FIFO_DEPTH)
	) frame_buffer (
		.clk(pclk),
		.rst_n(presetn),
		.in_valid(in_valid),
		.in_ready(in_ready),
		.in_data({in_right, in_left}),
		.out_valid(frame_valid),
		.out_ready(tick),
		.out_data(frame)
	);

	assign sample[0] = frame[SAMPLE_W-1:0];
	assign sample[1] = frame[FRAME_W-1:SAMPLE_W];

	// Per-channel zero-run counting and qualification
	for (genvar c = 0; c < 2; c++) begin : chan
		localparam int RUN_LSB = (c == 0) ? LEFT_RUN_LSB : RIGHT_RUN_LSB;
		localparam int ENABLE_BIT = (c == 0) ? LEFT_ENABLE_BIT : RIGHT_ENABLE_BIT;
		logic [RUN_W-1:0] limit;
		logic [RUN_W-1:0] run_next;

		// Fixed sample counts, so real time scales with the rate
		assign limit = zero_run_limit(q.auto_mute_duration[RUN_LSB +: RUN_CODE_W]) >> RUN_SHIFT;

		// Nonzero sample restarts the run; counter saturates at the limit
		always_comb begin
			if (tick && frame_valid) begin
				if (sample[c] != '0) begin
					run_next = '0;
				end else if (q.run[c] < limit) begin
					run_next = q.run[c] + RUN_W'(1);
				end else begin
					run_next = q.run[c];
				end
			end else begin
				run_next = q.run[c];
			end
		end

		// Local value keeps one process per shared vector slice
		assign next_run[c] = run_next;

		// Enable bit gates qualification
		assign qualify[c] = q.auto_mute_control[ENABLE_BIT] && run_next >= limit;
	end

	// Joint mode mutes only when both channels qualify
	assign want_mute = q.auto_mute_control[GROUP_MUTE_BIT] ? {2{&qualify}} : qualify;

	// Emergency ramp pacing and step size
	assign speed = q.emergency_ramp_control[EMERGENCY_SPEED_LSB +: 2];
	assign step = emergency_step(q.emergency_ramp_control[EMERGENCY_STEP_LSB +: 2]);
	always_comb begin
		case (speed)
			SPEED_EVERY_1: phase_mask = PHASE_MASK_1;
			SPEED_EVERY_2: phase_mask = PHASE_MASK_2;
			SPEED_EVERY_4: phase_mask = PHASE_MASK_4;
			default: phase_mask = PHASE_MASK_1;
		endcase
	end
	assign update_due = tick && ((q.phase & phase_mask) == 2'h0);

	// APB word decode; byte lanes below a word are not addressable
	assign index = paddr[ADDR_W-1:2];
	assign aligned = paddr[1:0] == 2'h0;

	// Next state
	always_comb begin
		next_q = q;
		sum = '0;

		// Setup phase latches read data so the access phase answers from flops
		next_q.ready = psel && !penable;
		if (psel && !penable) begin
			next_q.slverr = 1'b0;
			next_q.rdata = '0;
			if (!aligned) begin
				next_q.slverr = 1'b1;
			end else begin
				case (index)
					IDX_EMERGENCY_RAMP: next_q.rdata[7:0] = q.emergency_ramp_control;
					IDX_AUTO_MUTE_CONTROL: next_q.rdata[7:0] = q.auto_mute_control;
					IDX_AUTO_MUTE_DURATION: next_q.rdata[7:0] = q.auto_mute_duration;
					IDX_OUTPUT_STAGE_BANDWIDTH: next_q.rdata[7:0] = q.output_stage_bandwidth;
					IDX_MUTE_STATUS: begin
						next_q.rdata[STAT_LEFT_MUTED_BIT] = q.muted[0];
						next_q.rdata[STAT_RIGHT_MUTED_BIT] = q.muted[1];
						next_q.rdata[STAT_EMERGENCY_BIT] = q.emergency;
						next_q.rdata[STAT_LEFT_SILENT_BIT] = q.atten[0] == ATTEN_MUTE;
						next_q.rdata[STAT_RIGHT_SILENT_BIT] = q.atten[1] == ATTEN_MUTE;
					end
					default: next_q.slverr = 1'b1;
				endcase
			end
		end

		// Writes land on the completing access edge; status is read-only
		if (psel && penable && q.ready && pwrite && aligned) begin
			case (index)
				IDX_EMERGENCY_RAMP: next_q.emergency_ramp_control = pwdata[7:0];
				IDX_AUTO_MUTE_CONTROL: next_q.auto_mute_control = pwdata[7:0];
				IDX_AUTO_MUTE_DURATION: next_q.auto_mute_duration = pwdata[7:0];
				IDX_OUTPUT_STAGE_BANDWIDTH: next_q.output_stage_bandwidth = pwdata[7:0];
				default: next_q.ready = 1'b0;
			endcase
			next_q.ready = 1'b0;
		end

		// Sample-rate divider and ramp phase
		next_q.div = tick ? '0 : q.div + DIV_W'(1);
		if (tick) begin
			next_q.phase = q.phase + 2'h1;
		end

		// Fault state sampled every cycle
		next_q.emergency = clock_fault || supply_loss;

		// Zero runs and the auto-mute decision, one frame at a time
		next_q.run = next_run;
		if (tick && frame_valid) begin
			next_q.muted = want_mute;
		end

		// Attenuation ramp per channel
		for (int c = 0; c < 2; c++) begin
			if (q.emergency) begin
				if (speed == SPEED_INSTANT) begin
					next_q.atten[c] = ATTEN_MUTE;
				end else if (update_due) begin
					sum = {1'b0, q.atten[c]} + {1'b0, step};
					next_q.atten[c] = (sum > {1'b0, ATTEN_MUTE}) ? ATTEN_MUTE : sum[7:0];
				end
			end else if (tick) begin
				// Normal soft ramp toward mute or back to full level
				if (q.muted[c]) begin
					sum = {1'b0, q.atten[c]} + {1'b0, NORMAL_STEP};
					next_q.atten[c] = (sum > {1'b0, ATTEN_MUTE}) ? ATTEN_MUTE : sum[7:0];
				end else if (q.atten[c] > NORMAL_STEP) begin
					next_q.atten[c] = q.atten[c] - NORMAL_STEP;
				end else begin
					next_q.atten[c] = ATTEN_NONE;
				end
			end
		end

		// Output frame; gain scaling itself happens downstream, only hard mute is applied here
		next_q.ovalid = tick && frame_valid;
		if (tick && frame_valid) begin
			for (int c = 0; c < 2; c++) begin
				next_q.osample[c] = (q.atten[c] == ATTEN_MUTE) ? '0 : sample[c];
			end
		end
	end

	// State register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q <= '0;
			q.auto_mute_control <= RST_AUTO_MUTE_CONTROL;
			q.auto_mute_duration <= RST_AUTO_MUTE_DURATION;
			q.output_stage_bandwidth <= RST_OUTPUT_STAGE_BANDWIDTH;
			q.emergency_ramp_control <= RST_EMERGENCY_RAMP;
		end else begin
			q <= next_q;
		end
	end

	// Outputs straight from the state register
	assign prdata = q.rdata;
	assign pready = q.ready;
	assign pslverr = q.slverr;
	assign out_valid = q.ovalid;
	assign out_left = q.osample[0];
	assign out_right = q.osample[1];
	assign left_attenuation = q.atten[0];
	assign right_attenuation = q.atten[1];
	assign left_muted = q.muted[0];
	assign right_muted = q.muted[1];
	assign loop_bandwidth_select = q.output_stage_bandwidth[BANDWIDTH_LSB +: BANDWIDTH_W];
endmodule // auto_mute_ramp

// ---- test/audio_source_model.sv ----
// Sample source feeding frames into the block's stream input.
`timescale 1ns/1ns
module audio_source_model #(parameter int W = 24) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Bench controls
	input wire logic run,
	input wire logic zero_l,
	input wire logic zero_r,
	// Stream
	input wire logic ready,
	output logic valid,
	output logic [W-1:0] left,
	output logic [W-1:0] right
);
	logic [W-1:0] cnt;
	// Frame held until taken; idle data keeps changing, never a stale value
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			valid <= 1'b0;
			cnt <= 24'h00_0001;
			left <= '0;
			right <= '0;
		end else if (!valid || ready) begin
			valid <= run;
			cnt <= cnt + 1'b1;
			left <= zero_l ? '0 : cnt;
			right <= zero_r ? '0 : ~cnt;
		end
	end
endmodule // audio_source_model

// ---- test/auto_mute_ramp_monitor.sv ----
// Port checker for the auto-mute block.
`timescale 1ns/1ns
module auto_mute_ramp_monitor
	import auto_mute_pkg::*;
#(parameter int SAMPLE_W = 24) (
	// Bus
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [DATA_W-1:0] pwdata,
	input wire logic pready,
	input wire logic pslverr,
	// Stream and status
	input wire logic out_valid,
	input wire logic [SAMPLE_W-1:0] out_left,
	input wire logic [7:0] left_attenuation,
	input wire logic clock_fault,
	input wire logic supply_loss,
	input wire logic left_muted,
	input wire logic [BANDWIDTH_W-1:0] loop_bandwidth_select
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Bus handshake
	property p_ready; psel && !penable |=> pready; endproperty
	a_ready: assert property (p_ready) else $error("no pready");
	property p_pulse; pready |=> !pready; endproperty
	a_pulse: assert property (p_pulse) else $error("pready too long");
	property p_align; pready && paddr[1:0] != 2'h0 |-> pslverr; endproperty
	a_align: assert property (p_align) else $error("unaligned accepted");
	// Bandwidth pins follow writes only
	property p_bw_wr; psel && penable && pwrite && pready && paddr == 12'h14C
		|=> loop_bandwidth_select == $past(pwdata[6:5]); endproperty
	a_bw_wr: assert property (p_bw_wr) else $error("bandwidth not taken");
	property p_bw_hold; $changed(loop_bandwidth_select) |-> $past(pready && pwrite); endproperty
	a_bw_hold: assert property (p_bw_hold) else $error("bandwidth moved");
	// Large steps only while a fault is present
	property p_fault_step; {1'b0, left_attenuation} > {1'b0, $past(left_attenuation)} + 9'h001
		|-> $past(clock_fault || supply_loss) || $past(clock_fault || supply_loss, 2); endproperty
	a_fault_step: assert property (p_fault_step) else $error("step without fault");
	// Recovery is one half-dB step at a time
	property p_down; left_attenuation < $past(left_attenuation)
		|-> $past(left_attenuation) - left_attenuation == 8'h01; endproperty
	a_down: assert property (p_down) else $error("recovery step");
	// A frame is judged by the attenuation in force when it left, not by a stale held sample
	property p_silent; out_valid && $past(left_attenuation) == 8'hFF |-> out_left == '0; endproperty
	a_silent: assert property (p_silent) else $error("muted sample leaks");
	c_mute: cover property (out_valid && left_muted);
	c_err: cover property (pready && pslverr);
	c_full: cover property (left_attenuation == 8'hFF);
endmodule // auto_mute_ramp_monitor
bind auto_mute_ramp auto_mute_ramp_monitor #(.SAMPLE_W(SAMPLE_W)) mon (.pclk, .presetn, .psel, .penable,
	.pwrite, .paddr, .pwdata, .pready, .pslverr, .out_valid, .out_left, .left_attenuation, .clock_fault,
	.supply_loss, .left_muted, .loop_bandwidth_select);

// ---- test/test_auto_mute_ramp.sv ----
// Self-checking bench for the auto-mute block.
`timescale 1ns/1ns
module test_auto_mute_ramp
	import auto_mute_pkg::*;
;
	localparam int DIV = 8;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [ADDR_W-1:0] paddr = '0;
	logic [DATA_W-1:0] pwdata = '0, prdata, rd;
	logic pready, pslverr, er, in_valid, in_ready, out_valid;
	logic clock_fault = 0, supply_loss = 0, run = 0, zl = 0, zr = 0;
	logic [23:0] in_left, in_right, out_left, out_right;
	logic [7:0] left_attenuation, right_attenuation;
	logic left_muted, right_muted;
	logic [1:0] loop_bandwidth_select;
	int err_count = 0, samples_checked = 0;
	// Short sample period and zero runs keep the run brief
	auto_mute_ramp #(.SAMPLE_DIVIDER(DIV), .RUN_SHIFT(8)) DUT (.pclk, .presetn, .psel, .penable, .pwrite,
		.paddr, .pwdata, .prdata, .pready, .pslverr, .in_valid, .in_ready, .in_left, .in_right, .out_valid,
		.out_left, .out_right, .left_attenuation, .right_attenuation, .clock_fault, .supply_loss,
		.left_muted, .right_muted, .loop_bandwidth_select);
	audio_source_model src (.clk(pclk), .rst_n(presetn), .run, .zero_l(zl), .zero_r(zr), .ready(in_ready),
		.valid(in_valid), .left(in_left), .right(in_right));
	initial begin
		forever #5 pclk = ~pclk;
	end
	task automatic final_report();
		$display("checks %0d mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			err_count++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// One transfer; an idle edge after it so psel is never set twice at once
	task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d);
		psel <= 1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		// Waits as long as the slave needs; only the watchdog ends a hang
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 0;
		penable <= 0;
		@(posedge pclk);
	endtask
	task automatic rchk(input string what, input logic [ADDR_W-1:0] a, input logic [31:0] exp);
		apb(0, a, 0);
		chk(what, rd, exp);
	endtask
	task automatic frames(input int n);
		repeat (n * DIV) @(posedge pclk);
	endtask
	task automatic tick();
		do @(posedge pclk); while (out_valid !== 1'b1);
	endtask
	task automatic t_regs();
		rchk("emergency", 12'h13C, 32'h0000_0030);
		chk("no error", er, 0);
		rchk("control", 12'h140, 32'h0000_0007);
		rchk("duration", 12'h144, 32'h0000_0000);
		rchk("bandwidth", 12'h14C, 32'h0000_0000);
		apb(0, 12'h200, 0);
		chk("unmapped", er, 1);
		apb(0, 12'h141, 0);
		chk("unaligned", er, 1);
	endtask
	// Fill until refused while the block drains slowly, then drain
	task automatic t_fifo();
		int n;
		n = 0;
		run <= 1;
		while (in_ready !== 1'b0 && n < 60) begin
			@(posedge pclk);
			n++;
		end
		chk("full", in_ready, 0);
		run <= 0;
		frames(24);
		chk("drained", in_ready, 1);
		run <= 1;
	endtask
	task automatic t_bw();
		for (int c = 0; c < 4; c++) begin
			apb(1, 12'h14C, 32'h0000_009F | (c << 5));
			rchk("bw reg", 12'h14C, 32'h0000_009F | (c << 5));
			chk("bw pins", loop_bandwidth_select, c);
		end // Ends on the widest bandwidth
	endtask
	task automatic t_mute();
		apb(1, 12'h144, 32'h0000_0010);
		apb(1, 12'h140, 32'h0000_0003);
		frames(24);
		zl <= 1;
		zr <= 1;
		frames(26);
		chk("right short", right_muted, 1);
		chk("left long", left_muted, 0);
		frames(20);
		chk("left done", left_muted, 1);
		// Both channels muted, neither fully silent yet, no fault
		rchk("status muted", 12'h160, 32'h0000_0003);
		apb(1, 12'h140, 32'h0000_0001);
		frames(2);
		chk("right off", right_muted, 0);
		apb(1, 12'h140, 32'h0000_0006);
		frames(2);
		chk("left off", left_muted, 0);
		zr <= 0;
		apb(1, 12'h140, 32'h0000_0007);
		frames(22);
		chk("joint", left_muted, 0);
		apb(1, 12'h140, 32'h0000_0003);
		frames(2);
		chk("alone", left_muted, 1);
		zl <= 0;
		frames(22);
		chk("release", left_muted, 0);
		apb(1, 12'h140, 32'h0000_0000);
		frames(80);
		chk("restored", left_attenuation, 0);
	endtask
	// Depth after eight ticks is updates times step, from a phase-free window
	task automatic t_emerg();
		for (int s = 0; s < 3; s++) begin
			for (int t = 0; t < 4; t++) begin
				apb(1, 12'h13C, (s << 6) | (t << 4));
				chk("idle", right_attenuation, 0);
				tick();
				clock_fault <= !t[0];
				supply_loss <= t[0];
				repeat (8) tick();
				chk("depth", left_attenuation, (8 >> s) * (8 >> t));
				clock_fault <= 0;
				supply_loss <= 0;
				frames(70);
			end
		end
		apb(1, 12'h13C, 32'h0000_00F0);
		supply_loss <= 1;
		repeat (4) @(posedge pclk);
		chk("instant", left_attenuation, 8'hFF);
		// The frame already out may predate the drop; judge the next one
		tick();
		chk("silent", out_left, 0);
		chk("silent right", out_right, 0);
		// Fault flag and both silent flags up, auto-mute off
		rchk("status fault", 12'h160, 32'h0000_001C);
		supply_loss <= 0;
	endtask
	initial begin
		repeat (20) @(posedge pclk);
		presetn <= 1;
		@(posedge pclk);
		t_regs();
		t_fifo();
		t_bw();
		t_mute();
		t_emerg();
		final_report();
	end
	// Cuts a hang short
	initial begin
		#500_000;
		err_count++;
		final_report();
	end
endmodule // test_auto_mute_ramp
